// *** bench/ssz_partner_model.sv ***
// Host controller and encoder model facing the drive pins
module ssz_partner_model (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // Bench controls
   input wire logic clamp_on_i,
   input wire logic signed [15:0] speed_i,
   // Index seen from the drive
   input wire logic index_i,
   // Pins toward the drive, and the origin flag to the bench
   output logic enc_a_o,
   output logic enc_b_o,
   output logic clamp_request_n_o,
   output logic signed [15:0] motor_speed_o,
   output logic origin_ok_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_r = 2'h0;
   logic [1:0] turns_r;
   logic index_d_r;
   assign clamp_request_n_o = ~clamp_on_i;
   assign motor_speed_o = speed_i;
   // Quadrature levels, A leads B going forward
   assign enc_a_o = phase_r[1] ^ phase_r[0];
   assign enc_b_o = phase_r[1];
   // One count per call, spaced past the pin synchroniser
   task automatic step(input logic fwd);
      @(posedge sys_clk_i);
      phase_r <= fwd ? phase_r + 2'h1 : phase_r - 2'h1;
      repeat (3) @(posedge sys_clk_i);
   endtask
   always @(posedge sys_clk_i)
   begin
      index_d_r <= index_i;
      if (!resetn_i)
         turns_r <= 2'h0;
      else if (index_i && !index_d_r && turns_r != 2'h2)
         turns_r <= turns_r + 2'h1;
   end
   assign origin_ok_o = (turns_r == 2'h2);
endmodule

// *** bench/tb_servo_speed_shaping_zero_clamp.sv ***
// Self-checking bench for the speed shaping and zero clamp block
module tb_servo_speed_shaping_zero_clamp;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ZERO = 32'h0000_0000;
   localparam logic [31:0] ONE = 32'h0000_0001;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pa_d = 1'b0, pb_d = 1'b0;
   logic [31:0] pwdata = ZERO;
   logic [31:0] prdata, q;
   logic pready, pslverr, err;
   logic clamp_on = 1'b0, abs_req = 1'b1, abs_fit = 1'b0;
   logic signed [15:0] speed = 16'h0000;
   logic signed [15:0] motor_speed, speed_cmd;
   logic enc_a, enc_b, clamp_n, pa_p, pa_n, pb_p, pb_n, ix_p, ix_n;
   logic match_n, match_alt, abs_out, origin_ok;
   logic [31:0] cfgs [5] = '{32'h0000_0101, 32'h0000_0201, 32'h0000_0301,
      32'h0000_0002, 32'h0000_0012};
   int n_mismatch = 0, num_checks = 0, cycles = 0, a_rises = 0, b_rises = 0, a0, b0;
   // Clock
   initial
   begin
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   ssz_top #(.MS_CYC(10), .ENC_COUNTS(400)) dut_u (.sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .clamp_request_n_i(clamp_n), .enc_a_i(enc_a), .enc_b_i(enc_b),
      .absolute_position_request_i(abs_req), .abs_encoder_fitted_i(abs_fit),
      .motor_speed_i(motor_speed), .speed_cmd_o(speed_cmd), .phase_a_out_p_o(pa_p),
      .phase_a_out_n_o(pa_n), .phase_b_out_p_o(pb_p), .phase_b_out_n_o(pb_n),
      .index_out_p_o(ix_p), .index_out_n_o(ix_n), .speed_match_n_o(match_n),
      .speed_match_alt_o(match_alt), .abs_request_o(abs_out));
   ssz_partner_model pm_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
      .clamp_on_i(clamp_on), .speed_i(speed), .index_i(ix_p), .enc_a_o(enc_a),
      .enc_b_o(enc_b), .clamp_request_n_o(clamp_n), .motor_speed_o(motor_speed),
      .origin_ok_o(origin_ok));
   // Compare and count
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Verdict and end of run
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Pulse counters, differential pairs and hang limit
   always @(posedge sys_clk_i)
   begin
      cycles <= cycles + 1;
      pa_d <= pa_p;
      pb_d <= pb_p;
      if (pa_p && !pa_d)
         a_rises <= a_rises + 1;
      if (pb_p && !pb_d)
         b_rises <= b_rises + 1;
      if (resetn_i)
         check({29'h0, pa_n, pb_n, ix_n}, {29'h0, ~pa_p, ~pb_p, ~ix_p});
      if (cycles == 30000)
      begin
         n_mismatch++;
         close_out();
      end
   end
   // APB transfer: setup, access, wait for ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      do @(posedge sys_clk_i); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, ZERO);
      check(q, e);
   endtask
   // Clamp active flag from status
   task automatic stat(input logic e);
      repeat (10) @(posedge sys_clk_i);
      apb(1'b0, ssz_pkg::A_STATUS, ZERO);
      check({31'h0, q[1]}, {31'h0, e});
   endtask
   task automatic do_reset();
      @(posedge sys_clk_i);
      resetn_i <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
   endtask
   // Main sequence
   initial
   begin
      do_reset();
      rdc(ssz_pkg::A_PROFILE, ZERO);
      rdc(ssz_pkg::A_SRISE, ZERO);
      rdc(ssz_pkg::A_RAMP, ZERO);
      rdc(ssz_pkg::A_CLAMP, 32'h0000_000A);
      rdc(ssz_pkg::A_DIVIDE, 32'h0000_09C4);
      rdc(ssz_pkg::A_TOL, 32'h0000_000A);
      check({31'h0, abs_out}, ZERO);
      wr(ssz_pkg::A_CLAMP, 32'h0000_2EE0);
      rdc(ssz_pkg::A_CLAMP, 32'h0000_2710);
      wr(ssz_pkg::A_SRISE, 32'h0000_4E20);
      rdc(ssz_pkg::A_SRISE, 32'h0000_2710);
      wr(ssz_pkg::A_SRISE, ZERO);
      wr(ssz_pkg::A_CLAMP, 32'h0000_000A);
      apb(1'b0, 8'h40, ZERO);
      check({q[31:1], err}, ONE);
      // One ms per 1000 r/min: two steps take some 500 cycles
      wr(ssz_pkg::A_RAMP, ONE);
      wr(ssz_pkg::A_REF, 32'h0000_0002);
      repeat (10) @(posedge sys_clk_i);
      check({31'h0, speed_cmd === 16'h0002}, ZERO);
      repeat (600) @(posedge sys_clk_i);
      check(32'(speed_cmd), 32'h0000_0002);
      wr(ssz_pkg::A_RAMP, ZERO);
      // Filtered profiles must not jump to a step; S-curve ratio 0 reaches it within 20 cycles
      for (int i = 0; i < 6; i++)
      begin
         wr(ssz_pkg::A_PROFILE, ZERO);
         wr(ssz_pkg::A_REF, ZERO);
         repeat (20) @(posedge sys_clk_i);
         wr(ssz_pkg::A_PROFILE, (i < 5) ? cfgs[i] : ONE);
         wr(ssz_pkg::A_REF, 32'h0000_0040);
         repeat ((i < 5) ? 2 : 20) @(posedge sys_clk_i);
         check({31'h0, speed_cmd === 16'h0040}, (i < 5) ? ZERO : ONE);
      end
      wr(ssz_pkg::A_PROFILE, ZERO);
      wr(ssz_pkg::A_REF, 32'h0000_0005);
      clamp_on <= 1'b1;
      stat(1'b0);
      wr(ssz_pkg::A_MODE, 32'h0000_00A0);
      stat(1'b1);
      check(32'(speed_cmd), ZERO);
      repeat (3) pm_u.step(1'b1);
      repeat (8) @(posedge sys_clk_i);
      check(32'(speed_cmd), 32'hFFFF_FFF4);
      repeat (2) pm_u.step(1'b0);
      repeat (8) @(posedge sys_clk_i);
      check(32'(speed_cmd), ZERO);
      pm_u.step(1'b0);
      wr(ssz_pkg::A_REF, 32'h0000_000A);
      stat(1'b0);
      wr(ssz_pkg::A_CLAMP, 32'h0000_2710);
      wr(ssz_pkg::A_REF, 32'h0000_0BB8);
      stat(1'b0);
      wr(ssz_pkg::A_REF, 32'h0000_0005);
      stat(1'b1);
      clamp_on <= ~clamp_on;
      stat(1'b0);
      wr(ssz_pkg::A_MODE, ZERO);
      wr(ssz_pkg::A_REF, 32'h0000_0064);
      speed <= 16'h0069;
      repeat (6) @(posedge sys_clk_i);
      check({31'h0, match_n}, ZERO);
      speed <= speed + 16'sh0006;
      repeat (6) @(posedge sys_clk_i);
      check({31'h0, match_n}, ONE);
      wr(ssz_pkg::A_TOL, ZERO);
      speed <= 16'h0064;
      repeat (6) @(posedge sys_clk_i);
      check({31'h0, match_n}, ZERO);
      speed <= speed + 16'sh0001;
      repeat (6) @(posedge sys_clk_i);
      check({31'h0, match_n}, ONE);
      wr(ssz_pkg::A_MODE, 32'h0001_0000);
      speed <= 16'h0064;
      repeat (6) @(posedge sys_clk_i);
      check({30'h0, match_n, match_alt}, 32'h0000_0002);
      // Count below range is clipped to 16 at the next reset
      wr(ssz_pkg::A_DIVIDE, 32'h0000_0008);
      abs_fit <= 1'b1;
      do_reset();
      repeat (10) @(posedge sys_clk_i);
      check({31'h0, abs_out}, ONE);
      abs_req <= ~abs_req;
      repeat (10) @(posedge sys_clk_i);
      check({31'h0, abs_out}, ZERO);
      a0 = a_rises;
      b0 = b_rises;
      repeat (200) pm_u.step(1'b1);
      check({31'h0, ix_p}, ZERO);
      repeat (200) pm_u.step(1'b1);
      repeat (10) @(posedge sys_clk_i);
      check({31'h0, ix_p}, ONE);
      check(32'(a_rises - a0), 32'h0000_0010);
      check(32'(b_rises - b0), 32'h0000_0010);
      check({31'h0, origin_ok}, ZERO);
      repeat (400) pm_u.step(1'b1);
      repeat (10) @(posedge sys_clk_i);
      check({31'h0, origin_ok}, ONE);
      close_out();
   end
endmodule

// *** rtl/ssz_pkg.sv ***
// Shared constants for the speed shaping and zero clamp block
package ssz_pkg;
   // Register byte addresses
   localparam logic [7:0] A_PROFILE = 8'h00;
   localparam logic [7:0] A_MODE = 8'h04;
   localparam logic [7:0] A_RAMP = 8'h08;
   localparam logic [7:0] A_SRISE = 8'h0C;
   localparam logic [7:0] A_CLAMP = 8'h10;
   localparam logic [7:0] A_DIVIDE = 8'h14;
   localparam logic [7:0] A_REF = 8'h18;
   localparam logic [7:0] A_TOL = 8'h1C;
   localparam logic [7:0] A_STATUS = 8'h20;
   localparam logic [7:0] A_SPEED = 8'h24;
   // Field positions
   localparam int PROF_MODE_LSB = 0;
   localparam int PROF_ORDER_LSB = 4;
   localparam int PROF_RATIO_LSB = 8;
   localparam int MODE_CTRL_LSB = 4;
   localparam int MODE_ASSIGN_BIT = 16;
   localparam int RAMP_DEC_LSB = 16;
   // Codes
   localparam logic [3:0] PROF_TRAP = 4'h0;
   localparam logic [3:0] PROF_SCURVE = 4'h1;
   localparam logic [3:0] PROF_FILTER = 4'h2;
   localparam logic [3:0] CTRL_ZCLAMP = 4'hA;
   // Reset values and ranges
   localparam logic [15:0] RST_THRESH = 16'h000A;
   localparam logic [16:0] RST_DIVIDE = 17'h0_09C4;
   localparam logic [15:0] RST_TOL = 16'h000A;
   localparam logic [15:0] TIME_MAX = 16'h2710;
   localparam logic [15:0] THRESH_MAX = 16'h2710;
   localparam logic [16:0] DIV_MIN = 17'h0_0010;
   localparam logic [16:0] DIV_MAX = 17'h0_8000;
   localparam logic [1:0] FILT_SHIFT = 2'h3;
   // Timing: one ms of setting per 1000 r/min is one us per r/min
   localparam int CLK_MHZ = 250;
   localparam int RPM_STEP_NS = 1000;
   localparam int RAMP_UNIT_CYC = RPM_STEP_NS * CLK_MHZ / 1000;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = MS_NS / 1000 * CLK_MHZ / 1000;
   // Clamp states
   typedef enum logic {ST_RUN, ST_CLAMP} ssz_state_t;
endpackage

// *** rtl/ssz_top.sv ***
// Speed shaping, zero clamp, feedback divider and speed match output
//
// Function
// RULE1: Profile digit 1 selects S-curve shaping with a ratio digit of 0 to 3.
// RULE2: The S-curve rise time takes 0 to 10000 ms, resets to 0, acts at once.
// RULE3: Profile digit 2 selects accel/decel filtering, first or second order.
// RULE4: Clamp request active and reference under threshold locks the motor.
// RULE5: In clamp the motor is held within one count of the latched position.
// RULE6: Clamping only works when the control mode digit selects code A.
// RULE7: The clamp threshold takes 0 to 10000 r/min, resets to 10, capped at max.
// RULE8: The host drives the clamp request low to enable and high to disable.
// RULE9: Feedback is divided to 16..32768 pulses per rev on A/B with index C.
// RULE10: The host uses the index for origin return only after two turns.
// RULE11: The absolute position request is honoured only with an absolute encoder.
// RULE12: The speed match output is low on match and high otherwise.
// RULE13: The speed match signal may be routed to the alternate output.
// RULE14: Ramp times are per 1000 r/min and zero means no ramping.
// RULE15: Speed match uses a programmable tolerance band.
//
// Our own choices: the register offsets and the APB slave port.
module ssz_top #(
   parameter int MS_CYC = ssz_pkg::MS_CYC,
   parameter int ENC_COUNTS = 131072,
   parameter logic [15:0] MAX_SPEED = 16'h0BB8,
   parameter int KP_SHIFT = 2
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // APB slave
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Pins from host and encoder
   input wire logic clamp_request_n_i,
   input wire logic enc_a_i,
   input wire logic enc_b_i,
   input wire logic absolute_position_request_i,
   input wire logic abs_encoder_fitted_i,
   // Measured motor speed, same clock
   input wire logic signed [15:0] motor_speed_i,
   // Drive and pin outputs
   output logic signed [15:0] speed_cmd_o,
   output logic phase_a_out_p_o,
   output logic phase_a_out_n_o,
   output logic phase_b_out_p_o,
   output logic phase_b_out_n_o,
   output logic index_out_p_o,
   output logic index_out_n_o,
   output logic speed_match_n_o,
   output logic speed_match_alt_o,
   output logic abs_request_o
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [15:0] sat16(input logic [31:0] v, input logic [15:0] m);
      sat16 = (v > {16'h0000, m}) ? m : v[15:0];
   endfunction

   function automatic logic [16:0] abs17(input logic signed [16:0] v);
      abs17 = v[16] ? 17'(-v) : v;
   endfunction

   // One filter step toward x, never stalling short of it
   function automatic logic signed [15:0] filt(input logic signed [15:0] y,
      input logic signed [15:0] x, input logic [1:0] sh);
      logic signed [16:0] d;
      logic signed [16:0] s;
      d = 17'(x) - 17'(y);
      s = d >>> sh;
      if (s == 17'sh0_0000 && d != 17'sh0_0000)
         s = d[16] ? -17'sd1 : 17'sd1;
      filt = 16'(17'(y) + s);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: bit0 clamp_n, bit1 A, bit2 B, bit3 abs request
   logic [3:0] s1_r, s2_r, s3_r, pin_r, pin_nxt;
   logic [3:0] pins;
   assign pins = {absolute_position_request_i, enc_b_i, enc_a_i, clamp_request_n_i};

   // Accept a change once the second and third stages agree
   always_comb
   begin
      pin_nxt = (s2_r & ~(s2_r ^ s3_r)) | (pin_r & (s2_r ^ s3_r));
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         s1_r <= 4'h1;
         s2_r <= 4'h1;
         s3_r <= 4'h1;
         pin_r <= 4'h1;
      end
      else
      begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
         pin_r <= pin_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB register file
   logic [11:0] prof_r, prof_nxt;
   logic [3:0] ctl_r, ctl_nxt;
   logic asg_r, asg_nxt;
   logic [15:0] acc_t_r, acc_t_nxt, dec_t_r, dec_t_nxt, srise_r, srise_nxt;
   logic [15:0] thr_r, thr_nxt, tol_r, tol_nxt;
   // Divide setting survives reset, so a new count applies at the next reset
   logic [16:0] div_r = ssz_pkg::RST_DIVIDE;
   logic [16:0] div_nxt;
   logic signed [15:0] ref_r, ref_nxt;
   logic [31:0] rd_r, rd_nxt;
   logic rdy_r, rdy_nxt, err_r, err_nxt;
   logic signed [15:0] shaped, cmd_r;
   logic match_r;
   ssz_pkg::ssz_state_t st_r, st_nxt;
   logic wr_done, mapped;
   logic [31:0] rdata;
   assign wr_done = psel_i & penable_i & rdy_r & pwrite_i;

   // Address decode and read mux
   always_comb
   begin
      mapped = 1'b1;
      rdata = 32'h0000_0000;
      case (paddr_i)
         ssz_pkg::A_PROFILE: rdata = {20'h0_0000, prof_r};
         ssz_pkg::A_MODE: rdata = {15'h0000, asg_r, 8'h00, ctl_r, 4'h0};
         ssz_pkg::A_RAMP: rdata = {dec_t_r, acc_t_r};
         ssz_pkg::A_SRISE: rdata = {16'h0000, srise_r};
         ssz_pkg::A_CLAMP: rdata = {16'h0000, thr_r};
         ssz_pkg::A_DIVIDE: rdata = {15'h0000, div_r};
         ssz_pkg::A_REF: rdata = {16'h0000, ref_r};
         ssz_pkg::A_TOL: rdata = {16'h0000, tol_r};
         ssz_pkg::A_STATUS: rdata = {29'h0000_0000, match_r, st_r == ssz_pkg::ST_CLAMP, pin_r[0]};
         ssz_pkg::A_SPEED: rdata = {cmd_r, shaped};
         default: mapped = 1'b0;
      endcase
   end

   // Register writes; ramp, rise time and threshold settings above range saturate
   always_comb
   begin
      prof_nxt = prof_r;
      ctl_nxt = ctl_r;
      asg_nxt = asg_r;
      acc_t_nxt = acc_t_r;
      dec_t_nxt = dec_t_r;
      srise_nxt = srise_r;
      thr_nxt = thr_r;
      div_nxt = div_r;
      ref_nxt = ref_r;
      tol_nxt = tol_r;
      rdy_nxt = psel_i & penable_i & ~rdy_r;
      rd_nxt = rdy_nxt ? rdata : rd_r;
      err_nxt = rdy_nxt & ~mapped;
      if (wr_done)
      begin
         case (paddr_i)
            ssz_pkg::A_PROFILE: prof_nxt = pwdata_i[11:0];
            ssz_pkg::A_MODE:
            begin
               ctl_nxt = pwdata_i[ssz_pkg::MODE_CTRL_LSB +: 4];
               asg_nxt = pwdata_i[ssz_pkg::MODE_ASSIGN_BIT];
            end
            ssz_pkg::A_RAMP:
            begin
               acc_t_nxt = sat16({16'h0000, pwdata_i[15:0]}, ssz_pkg::TIME_MAX);
               dec_t_nxt = sat16({16'h0000, pwdata_i[31:16]}, ssz_pkg::TIME_MAX);
            end
            // RULE2: rise time range
            ssz_pkg::A_SRISE: srise_nxt = sat16(pwdata_i, ssz_pkg::TIME_MAX);
            // RULE7: threshold range
            ssz_pkg::A_CLAMP: thr_nxt = sat16(pwdata_i, ssz_pkg::THRESH_MAX);
            ssz_pkg::A_DIVIDE: div_nxt = pwdata_i[16:0];
            ssz_pkg::A_REF: ref_nxt = pwdata_i[15:0];
            ssz_pkg::A_TOL: tol_nxt = pwdata_i[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         prof_r <= 12'h000;
         ctl_r <= 4'h0;
         asg_r <= 1'b0;
         acc_t_r <= 16'h0000;
         dec_t_r <= 16'h0000;
         srise_r <= 16'h0000;
         thr_r <= ssz_pkg::RST_THRESH;
         ref_r <= 16'h0000;
         tol_r <= ssz_pkg::RST_TOL;
         rd_r <= 32'h0000_0000;
         rdy_r <= 1'b0;
         err_r <= 1'b0;
      end
      else
      begin
         prof_r <= prof_nxt;
         ctl_r <= ctl_nxt;
         asg_r <= asg_nxt;
         acc_t_r <= acc_t_nxt;
         dec_t_r <= dec_t_nxt;
         srise_r <= srise_nxt;
         thr_r <= thr_nxt;
         div_r <= div_nxt;
         ref_r <= ref_nxt;
         tol_r <= tol_nxt;
         rd_r <= rd_nxt;
         rdy_r <= rdy_nxt;
         err_r <= err_nxt;
      end
   end

   assign prdata_o = rd_r;
   assign pready_o = rdy_r;
   assign pslverr_o = err_r;

   ////////////////////////////////////////////////////////////////////////
   // Reference shaping: ramp, S-curve filter, accel/decel filters
   logic [3:0] pmode, ratio;
   logic order2;
   assign pmode = prof_r[ssz_pkg::PROF_MODE_LSB +: 4];
   assign order2 = prof_r[ssz_pkg::PROF_ORDER_LSB];
   assign ratio = prof_r[ssz_pkg::PROF_RATIO_LSB +: 4];
   logic signed [15:0] ramp_r, ramp_nxt, f1_r, f1_nxt, f2_r, f2_nxt;
   logic [31:0] rcnt_r, rcnt_nxt, mcnt_r, mcnt_nxt, period;
   logic [15:0] tsel;
   logic up, accel, tick;
   assign tick = (mcnt_r == 32'(MS_CYC - 1));

   always_comb
   begin
      up = ref_r > ramp_r;
      accel = up ? (ramp_r >= 16'sh0000) : (ramp_r <= 16'sh0000);
      // RULE2: S-curve uses its rise time as the ramp time
      tsel = (pmode == ssz_pkg::PROF_SCURVE) ? srise_r : (accel ? acc_t_r : dec_t_r);
      period = 32'(tsel) * 32'(ssz_pkg::RAMP_UNIT_CYC);
      mcnt_nxt = tick ? 32'h0000_0000 : mcnt_r + 32'h0000_0001;
      rcnt_nxt = rcnt_r;
      ramp_nxt = ramp_r;
      // RULE14: one r/min per tsel us, zero time passes the step
      if (tsel == 16'h0000)
      begin
         ramp_nxt = ref_r;
         rcnt_nxt = 32'h0000_0000;
      end
      else if (ref_r != ramp_r)
      begin
         rcnt_nxt = (rcnt_r >= period - 32'h0000_0001) ? 32'h0000_0000 : rcnt_r + 32'h0000_0001;
         if (rcnt_nxt == 32'h0000_0000)
            ramp_nxt = up ? ramp_r + 16'sh0001 : ramp_r - 16'sh0001;
      end
      f1_nxt = f1_r;
      f2_nxt = f2_r;
      if (tick)
      begin
         // RULE3: first or second order filtering
         if (pmode == ssz_pkg::PROF_FILTER)
         begin
            f1_nxt = filt(f1_r, ref_r, ssz_pkg::FILT_SHIFT);
            f2_nxt = order2 ? filt(f2_r, f1_r, ssz_pkg::FILT_SHIFT) : f1_r;
         end
         // RULE1: S-curve rounding, ratio 0 nearly linear
         else
         begin
            f1_nxt = ramp_r;
            f2_nxt = filt(f2_r, ramp_r, ratio[1:0]);
         end
      end
      shaped = (pmode == ssz_pkg::PROF_SCURVE || pmode == ssz_pkg::PROF_FILTER) ? f2_r : ramp_r;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         ramp_r <= 16'sh0000;
         f1_r <= 16'sh0000;
         f2_r <= 16'sh0000;
         rcnt_r <= 32'h0000_0000;
         mcnt_r <= 32'h0000_0000;
      end
      else
      begin
         ramp_r <= ramp_nxt;
         f1_r <= f1_nxt;
         f2_r <= f2_nxt;
         rcnt_r <= rcnt_nxt;
         mcnt_r <= mcnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Encoder decode, position and frozen divide setting
   logic [1:0] g_r, g_nxt, oq_r, oq_nxt, dg;
   logic signed [31:0] pos_r, pos_nxt;
   logic [17:0] rev_r, rev_nxt, acc_r, acc_nxt, inc;
   logic [16:0] dv_r, dv_nxt;
   logic ld_r, absf_r, absf_nxt, fwd, bwd;

   always_comb
   begin
      g_nxt = {pin_r[2], pin_r[1] ^ pin_r[2]};
      dg = g_nxt - g_r;
      fwd = (dg == 2'h1);
      bwd = (dg == 2'h3);
      pos_nxt = pos_r + (fwd ? 32'sd1 : 32'sd0) - (bwd ? 32'sd1 : 32'sd0);
      rev_nxt = rev_r;
      if (fwd)
         rev_nxt = (rev_r == 18'(ENC_COUNTS - 1)) ? 18'h0_0000 : rev_r + 18'h0_0001;
      else if (bwd)
         rev_nxt = (rev_r == 18'h0_0000) ? 18'(ENC_COUNTS - 1) : rev_r - 18'h0_0001;
      // RULE9: count latched once after reset, needs a reset to change
      dv_nxt = dv_r;
      absf_nxt = absf_r;
      if (!ld_r)
      begin
         dv_nxt = (div_r < ssz_pkg::DIV_MIN) ? ssz_pkg::DIV_MIN :
                  (div_r > ssz_pkg::DIV_MAX) ? ssz_pkg::DIV_MAX : div_r;
         absf_nxt = abs_encoder_fitted_i;
      end
      // RULE9: four output edges per divided pulse
      inc = {dv_r, 1'b0} << 1;
      acc_nxt = acc_r;
      oq_nxt = oq_r;
      if (fwd)
      begin
         acc_nxt = acc_r + inc;
         if (acc_nxt >= 18'(ENC_COUNTS))
         begin
            acc_nxt = acc_nxt - 18'(ENC_COUNTS);
            oq_nxt = oq_r + 2'h1;
         end
      end
      else if (bwd)
      begin
         acc_nxt = acc_r - inc;
         if (acc_r < inc)
         begin
            acc_nxt = acc_nxt + 18'(ENC_COUNTS);
            oq_nxt = oq_r - 2'h1;
         end
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         g_r <= 2'h0;
         pos_r <= 32'sh0000_0000;
         rev_r <= 18'h0_0000;
         acc_r <= 18'h0_0000;
         oq_r <= 2'h0;
         dv_r <= ssz_pkg::RST_DIVIDE;
         absf_r <= 1'b0;
         ld_r <= 1'b0;
      end
      else
      begin
         g_r <= g_nxt;
         pos_r <= pos_nxt;
         rev_r <= rev_nxt;
         acc_r <= acc_nxt;
         oq_r <= oq_nxt;
         dv_r <= dv_nxt;
         absf_r <= absf_nxt;
         ld_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Zero clamp, command mux, speed match and pin outputs
   logic signed [31:0] hold_r, hold_nxt, perr;
   logic signed [15:0] cmd_nxt, pcmd;
   logic [15:0] thr_eff;
   logic zc_mode, clamp_cond, near, match_nxt;
   logic [8:0] pins_r, pins_nxt;

   always_comb
   begin
      // RULE7: threshold capped at motor maximum
      thr_eff = (thr_r > MAX_SPEED) ? MAX_SPEED : thr_r;
      // RULE6: clamp only in speed-with-clamp mode
      zc_mode = (ctl_r == ssz_pkg::CTRL_ZCLAMP);
      // RULE4: request low and reference below threshold
      clamp_cond = zc_mode && !pin_r[0] && abs17(17'(ref_r)) < 17'(thr_eff);
      st_nxt = clamp_cond ? ssz_pkg::ST_CLAMP : ssz_pkg::ST_RUN;
      hold_nxt = (clamp_cond && st_r == ssz_pkg::ST_RUN) ? pos_r : hold_r;
      // RULE5: drive back to latched position, one count deadband
      perr = hold_r - pos_r;
      near = (perr >= -32'sd1) && (perr <= 32'sd1);
      if (near)
         pcmd = 16'sh0000;
      else if (perr > 32'sd8191)
         pcmd = 16'sh7FFF;
      else if (perr < -32'sd8191)
         pcmd = -16'sh7FFF;
      else
         pcmd = 16'(perr <<< KP_SHIFT);
      cmd_nxt = (st_r == ssz_pkg::ST_CLAMP) ? pcmd : shaped;
      // RULE15: tolerance band around the reference
      match_nxt = abs17(17'(motor_speed_i) - 17'(shaped)) <= 17'(tol_r);
      // RULE12: low on match; RULE13: routed by assignment bit
      pins_nxt[0] = asg_r | ~match_r;
      pins_nxt[1] = ~asg_r | ~match_r;
      pins_nxt[2] = oq_r[0] ^ oq_r[1];
      pins_nxt[3] = oq_r[1];
      pins_nxt[4] = (rev_r == 18'h0_0000);
      // RULE11: request only passed with an absolute encoder
      pins_nxt[5] = absf_r & pin_r[3];
      // Inverted halves of the pairs, registered as well
      pins_nxt[8:6] = ~pins_nxt[4:2];
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!resetn_i)
      begin
         st_r <= ssz_pkg::ST_RUN;
         hold_r <= 32'sh0000_0000;
         cmd_r <= 16'sh0000;
         match_r <= 1'b0;
         pins_r <= 9'h0D3;
      end
      else
      begin
         st_r <= st_nxt;
         hold_r <= hold_nxt;
         cmd_r <= cmd_nxt;
         match_r <= match_nxt;
         pins_r <= pins_nxt;
      end
   end

   assign speed_cmd_o = cmd_r;
   assign speed_match_n_o = pins_r[0];
   assign speed_match_alt_o = pins_r[1];
   assign phase_a_out_p_o = pins_r[2];
   assign phase_a_out_n_o = pins_r[6];
   assign phase_b_out_p_o = pins_r[3];
   assign phase_b_out_n_o = pins_r[7];
   assign index_out_p_o = pins_r[4];
   assign index_out_n_o = pins_r[8];
   assign abs_request_o = pins_r[5];

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   sequence seq_enter;
      clamp_cond && st_r == ssz_pkg::ST_RUN;
   endsequence
   sequence seq_locked;
      st_r == ssz_pkg::ST_CLAMP && hold_r == $past(pos_r);
   endsequence

   chk_clamp_entry: assert property (seq_enter |=> seq_locked) // RULE4
      else $error("clamp entry did not latch position");
   chk_clamp_mode: assert property (!zc_mode |=> st_r == ssz_pkg::ST_RUN) // RULE6
      else $error("clamp outside clamp mode");
   chk_hold_band: assert property ( // RULE5
      st_r == ssz_pkg::ST_CLAMP && near |=> speed_cmd_o == 16'sh0000)
      else $error("clamp drives inside deadband");
   chk_thresh_cap: assert property ( // RULE7
      thr_r > MAX_SPEED && zc_mode && !pin_r[0] && abs17(17'(ref_r)) >= 17'(MAX_SPEED)
      |=> st_r == ssz_pkg::ST_RUN)
      else $error("threshold not capped");
   chk_match_level: assert property ( // RULE12
      !asg_r && !asg_nxt |=> ##1 speed_match_n_o == !$past(match_r))
      else $error("match level wrong");
   chk_match_route: assert property ( // RULE13
      asg_r |=> speed_match_n_o && speed_match_alt_o == !$past(match_r))
      else $error("match routing wrong");
   chk_div_frozen: assert property (ld_r |=> $stable(dv_r)) // RULE9
      else $error("divide count changed after load");
   chk_abs_ignore: assert property (!absf_r |=> !abs_request_o) // RULE11
      else $error("abs request passed without encoder");
   chk_ramp_bypass: assert property ( // RULE14
      pmode == ssz_pkg::PROF_TRAP && acc_t_r == 16'h0000 && dec_t_r == 16'h0000
      |=> ramp_r == $past(ref_r))
      else $error("zero ramp time did not pass step");
   chk_filter_first: assert property ( // RULE3
      tick && pmode == ssz_pkg::PROF_FILTER && !order2 |=> f2_r == $past(f1_r))
      else $error("first order filter path wrong");

endmodule
